// file: hw/scmc_defs.vh
// Constants for the serializer clock mode control block
`ifndef SCMC_DEFS_VH
`define SCMC_DEFS_VH

// =====================================================
// Register indices (byte address is four times index)
`define SCMC_IDX_MODE 6'h03
`define SCMC_IDX_FMT 6'h04
`define SCMC_IDX_OSC 6'h05
`define SCMC_IDX_PLLM 6'h06
`define SCMC_IDX_PLLN 6'h07
`define SCMC_IDX_VCFG 6'h10
`define SCMC_IDX_VDT 6'h11
`define SCMC_IDX_STAT 6'h12

// =====================================================
// Mode codes
`define SCMC_MODE_SYNC 3'h0
`define SCMC_MODE_EXT 3'h2
`define SCMC_MODE_INT 3'h3
`define SCMC_MODE_LEGACY 3'h5

// Reference source codes
`define SCMC_SRC_NONE 2'h0
`define SCMC_SRC_BC 2'h1
`define SCMC_SRC_EXT 2'h2
`define SCMC_SRC_AON 2'h3

// =====================================================
// Field positions
`define SCMC_MODE_FLD 2:0
`define SCMC_MODE_OVR_BIT 4
`define SCMC_FMT_OVR_BIT 0
`define SCMC_FMT_R12_BIT 1
`define SCMC_OSC_SEL_BIT 3
`define SCMC_PLLM_FLD 4:0
`define SCMC_PLLD_FLD 7:5
`define SCMC_VCFG_LONG_BIT 0
`define SCMC_VCFG_YUV_BIT 1
`define SCMC_VCFG_DTM_BIT 2
`define SCMC_VDT_FLD 5:0

// =====================================================
// Reset values
`define SCMC_RST_MODE 3'h0
`define SCMC_RST_OSC 8'h00
`define SCMC_RST_DIVC 3'h2
`define SCMC_RST_M 5'h01
`define SCMC_RST_N 8'h04
`define SCMC_RST_VCFG 3'h0
`define SCMC_RST_VDT 6'h00

`endif

// file: hw/scmc_sync.v
// Two-flop synchroniser with rising-edge pulse
`timescale 1ns/100ps
`default_nettype none

module scmc_sync #(
    parameter W = 1
) (
    input wire clk,
    input wire arst_n,
    input wire [W-1:0] d,
    output reg [W-1:0] q_ff,
    output wire [W-1:0] rise
);
    reg [W-1:0] meta_ff;
    reg [W-1:0] last_ff;

    // First stage feeds only the second stage
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_ff <= {W{1'b0}};
            q_ff <= {W{1'b0}};
            last_ff <= {W{1'b0}};
        end else begin
            meta_ff <= d;
            q_ff <= meta_ff;
            last_ff <= q_ff;
        end
    end

    assign rise = q_ff & ~last_ff;
endmodule // scmc_sync

`default_nettype wire

// file: hw/scmc_dpll.v
// Fractional digital PLL producing the sensor reference clock
`timescale 1ns/100ps
`default_nettype none

module scmc_dpll (
    input wire clk,
    input wire arst_n,
    input wire fc_tick,
    input wire [2:0] div_code,
    input wire [4:0] mult,
    input wire [7:0] ndiv,
    output reg clk_ff
);
    reg [7:0] pre_ff;
    reg [9:0] acc_ff;
    wire [7:0] div_last;
    wire hs_tick;
    wire [9:0] sum;
    wire [9:0] nval;

    // Divider is a power of two: 1,2,4 .. 128
    assign div_last = (8'h01 << div_code) - 8'h01;
    assign hs_tick = fc_tick && (pre_ff == div_last);
    // Two phase steps per output period, so M is doubled
    assign sum = acc_ff + {4'h0, mult, 1'b0};
    assign nval = (ndiv == 8'h00) ? 10'h001 : {2'b00, ndiv};

    // Integer N/M gives even edge spacing; otherwise edges wander
    // by one divided period, which a small divider keeps short.
    // Ratios with twice M above N cannot be followed. (see [R14])
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pre_ff <= 8'h00;
            acc_ff <= 10'h000;
            clk_ff <= 1'b0;
        end else begin
            if (fc_tick) begin
                pre_ff <= hs_tick ? 8'h00 : pre_ff + 8'h01;
            end
            if (hs_tick) begin
                if (sum >= nval) begin
                    acc_ff <= sum - nval; // see [R12]
                    clk_ff <= ~clk_ff;
                end else begin
                    acc_ff <= sum;
                end
            end
        end
    end
endmodule // scmc_dpll

`default_nettype wire

// file: hw/scmc_clock_mode_ctrl.v
// Clock mode control top with APB register file
`timescale 1ns/100ps
`default_nettype none
`include "scmc_defs.vh"

// Notes on behaviour
// [R1] External mode derives line and sensor clocks from input
// [R2] Camera throughput must stay below line rate
// [R3] Internal mode references always-on oscillator only
// [R4] Software sets oscillator select for full rate
// [R5] Sensor clock off in internal mode
// [R6] Mode field always reports active mode
// [R7] Mode field writable only with override bit
// [R8] Strap captured on power-down release edge
// [R9] Legacy video mode encoded as five
// [R10] Codes: zero sync, two external, three internal
// [R11] Legacy mode camera data synchronous to input
// [R12] Sensor clock is rate times M over divN
// [R13] Divided line rate must stay under limit
// [R14] Integer N/M ratio gives low jitter
// [R15] Prefer small divider when ratio not integer
// [R16] Four modes, default from strap pin
// [R17] Mode readable and changeable through registers
// [R18] Format override register selects raw10 or raw12
// [R19] Video config selects carried data kinds
// [R20] Datatype register passes matching packets
// [R21] Low-frequency raw12 format not supported
// [R22] Sync mode uses back-channel recovered clock
// [R23] Divider normally sixteen, eight or four
module scmc_clock_mode_ctrl #(
    parameter AON_DIV = 2
) (
    input wire clk,
    input wire arst_n,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata_ff,
    output reg pready_ff,
    output reg pslverr_ff,
    // Pins
    input wire powerdown_n,
    input wire [2:0] mode_strap,
    input wire ref_clock_input,
    input wire bc_recovered_clk,
    // Clock outputs
    output reg sensor_clk_out_ff,
    output reg sensor_clk_oe_ff,
    output reg fc_ref_tick_ff,
    output reg [1:0] ref_source_ff,
    output reg legacy_video_active_ff,
    // Legacy video controls
    output reg fmt_override_ff,
    output reg fmt_raw12_ff,
    output reg pass_long_ff,
    output reg pass_yuv_ff,
    output reg datatype_match_enable_ff,
    output reg [5:0] legacy_datatype_ff
);
    // =====================================================
    // Pin synchronisers
    // Pins are asynchronous to clk, so each passes two flops
    // before any edge detection or decode reads it.
    wire [2:0] strap_q;
    wire [2:0] pin_q;
    wire [2:0] pin_rise;
    wire pdn_rise;
    wire ref_rise;
    wire bc_rise;

    scmc_sync #(.W(3)) u_strap_sync (
        .clk(clk),
        .arst_n(arst_n),
        .d(mode_strap),
        .q_ff(strap_q),
        .rise()
    );

    scmc_sync #(.W(3)) u_pin_sync (
        .clk(clk),
        .arst_n(arst_n),
        .d({bc_recovered_clk, ref_clock_input, powerdown_n}),
        .q_ff(pin_q),
        .rise(pin_rise)
    );

    assign pdn_rise = pin_rise[0];
    assign ref_rise = pin_rise[1];
    assign bc_rise = pin_rise[2];

    // =====================================================
    // Registers
    // Mode, oscillator and PLL fields live here; the read mux gathers them by index
    reg [2:0] mode_ff;
    reg mode_ovr_ff;
    reg [7:0] osc_reg_ff;
    reg [2:0] div_code_ff;
    reg [4:0] mult_ff;
    reg [7:0] ndiv_ff;

    // =====================================================
    // APB decode
    wire [5:0] idx;
    wire setup;
    wire wr_en;

    function known_idx;
        input [5:0] i;
        begin
            case (i)
                `SCMC_IDX_MODE, `SCMC_IDX_FMT, `SCMC_IDX_OSC,
                `SCMC_IDX_PLLM, `SCMC_IDX_PLLN, `SCMC_IDX_VCFG,
                `SCMC_IDX_VDT, `SCMC_IDX_STAT: known_idx = 1'b1;
                default: known_idx = 1'b0;
            endcase
        end
    endfunction

    assign idx = paddr[7:2];
    assign setup = psel && !penable;
    // A write lands only in the completing access cycle
    assign wr_en = psel && penable && pready_ff && pwrite
                   && known_idx(idx);

    // =====================================================
    // Read data mux
    reg [31:0] nxt_rdata;

    always @* begin
        nxt_rdata = 32'h0000_0000;
        case (idx)
            `SCMC_IDX_MODE: begin
                nxt_rdata[`SCMC_MODE_FLD] = mode_ff; // see [R6]
                nxt_rdata[`SCMC_MODE_OVR_BIT] = mode_ovr_ff;
            end
            `SCMC_IDX_FMT: begin
                nxt_rdata[`SCMC_FMT_OVR_BIT] = fmt_override_ff;
                nxt_rdata[`SCMC_FMT_R12_BIT] = fmt_raw12_ff;
            end
            `SCMC_IDX_OSC: nxt_rdata[7:0] = osc_reg_ff;
            `SCMC_IDX_PLLM: begin
                nxt_rdata[`SCMC_PLLD_FLD] = div_code_ff;
                nxt_rdata[`SCMC_PLLM_FLD] = mult_ff;
            end
            `SCMC_IDX_PLLN: nxt_rdata[7:0] = ndiv_ff;
            `SCMC_IDX_VCFG: begin
                nxt_rdata[`SCMC_VCFG_LONG_BIT] = pass_long_ff;
                nxt_rdata[`SCMC_VCFG_YUV_BIT] = pass_yuv_ff;
                nxt_rdata[`SCMC_VCFG_DTM_BIT] =
                    datatype_match_enable_ff;
            end
            `SCMC_IDX_VDT: nxt_rdata[`SCMC_VDT_FLD] = legacy_datatype_ff;
            `SCMC_IDX_STAT: begin
                nxt_rdata[1:0] = ref_source_ff;
                nxt_rdata[2] = sensor_clk_oe_ff;
                nxt_rdata[3] = legacy_video_active_ff;
                nxt_rdata[6:4] = strap_q;
                nxt_rdata[7] = pin_q[0];
            end
            default: nxt_rdata = 32'h0000_0000;
        endcase
    end

    // Answer is prepared in the setup cycle, so access takes one cycle
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata_ff <= 32'h0000_0000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff <= setup;
            if (setup) begin
                prdata_ff <= pwrite ? 32'h0000_0000 : nxt_rdata;
                pslverr_ff <= !known_idx(idx);
            end else begin
                pslverr_ff <= 1'b0;
            end
        end
    end

    // =====================================================
    // Mode register
    // Strap capture wins over a software write in the same cycle,
    // since power-down release restarts the device's setup.
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_ff <= `SCMC_RST_MODE;
            mode_ovr_ff <= 1'b0;
        end else if (pdn_rise) begin
            mode_ff <= strap_q; // see [R8] [R16]
        end else if (wr_en && idx == `SCMC_IDX_MODE) begin
            mode_ovr_ff <= pwdata[`SCMC_MODE_OVR_BIT];
            if (mode_ovr_ff) begin
                mode_ff <= pwdata[`SCMC_MODE_FLD]; // see [R7] [R17]
            end
        end
    end

    // =====================================================
    // Plain control registers
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            osc_reg_ff <= `SCMC_RST_OSC;
            div_code_ff <= `SCMC_RST_DIVC;
            mult_ff <= `SCMC_RST_M;
            ndiv_ff <= `SCMC_RST_N;
            fmt_override_ff <= 1'b0;
            fmt_raw12_ff <= 1'b0;
            pass_long_ff <= 1'b0;
            pass_yuv_ff <= 1'b0;
            datatype_match_enable_ff <= 1'b0;
            legacy_datatype_ff <= `SCMC_RST_VDT;
        end else if (wr_en) begin
            case (idx)
                `SCMC_IDX_FMT: begin
                    // Only raw10 and high-frequency raw12 exist
                    fmt_override_ff <= pwdata[`SCMC_FMT_OVR_BIT];
                    fmt_raw12_ff <= pwdata[`SCMC_FMT_R12_BIT];
                end // see [R18] [R21]
                `SCMC_IDX_OSC: osc_reg_ff <= pwdata[7:0]; // see [R4]
                `SCMC_IDX_PLLM: begin
                    div_code_ff <= pwdata[`SCMC_PLLD_FLD];
                    mult_ff <= pwdata[`SCMC_PLLM_FLD];
                end // see [R12]
                `SCMC_IDX_PLLN: ndiv_ff <= pwdata[7:0]; // see [R12]
                `SCMC_IDX_VCFG: begin
                    pass_long_ff <= pwdata[`SCMC_VCFG_LONG_BIT];
                    pass_yuv_ff <= pwdata[`SCMC_VCFG_YUV_BIT];
                    datatype_match_enable_ff <=
                        pwdata[`SCMC_VCFG_DTM_BIT];
                end // see [R19]
                `SCMC_IDX_VDT:
                    legacy_datatype_ff <= pwdata[`SCMC_VDT_FLD]; // see [R20]
                default: ;
            endcase
        end
    end

    // =====================================================
    // Always-on oscillator, as an enable pulse
    // Without oscillator select only every other pulse is used,
    // which halves the reachable line rate.
    localparam [7:0] AON_LAST = AON_DIV - 1;
    reg [7:0] aon_cnt_ff;
    reg aon_half_ff;
    wire aon_pulse;
    wire aon_tick;

    assign aon_pulse = (aon_cnt_ff == AON_LAST);
    assign aon_tick = aon_pulse
                      && (osc_reg_ff[`SCMC_OSC_SEL_BIT] || aon_half_ff);

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            aon_cnt_ff <= 8'h00;
            aon_half_ff <= 1'b0;
        end else begin
            aon_cnt_ff <= aon_pulse ? 8'h00 : aon_cnt_ff + 8'h01;
            if (aon_pulse) begin
                aon_half_ff <= ~aon_half_ff; // see [R4]
            end
        end
    end

    // =====================================================
    // Reference selection
    reg nxt_tick;
    reg [1:0] nxt_src;
    reg nxt_oe;

    always @* begin
        nxt_tick = 1'b0;
        nxt_src = `SCMC_SRC_NONE;
        nxt_oe = 1'b0;
        case (mode_ff) // see [R10] [R9]
            `SCMC_MODE_SYNC: begin
                nxt_tick = bc_rise; // see [R22]
                nxt_src = `SCMC_SRC_BC;
                nxt_oe = 1'b1;
            end
            `SCMC_MODE_EXT, `SCMC_MODE_LEGACY: begin
                nxt_tick = ref_rise; // see [R1]
                nxt_src = `SCMC_SRC_EXT;
                nxt_oe = 1'b1;
            end
            `SCMC_MODE_INT: begin
                nxt_tick = aon_tick; // see [R3]
                nxt_src = `SCMC_SRC_AON;
                nxt_oe = 1'b0; // see [R5]
            end
            default: begin
                nxt_tick = 1'b0;
                nxt_src = `SCMC_SRC_NONE;
                nxt_oe = 1'b0;
            end
        endcase
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fc_ref_tick_ff <= 1'b0;
            ref_source_ff <= `SCMC_SRC_NONE;
            sensor_clk_oe_ff <= 1'b0;
            legacy_video_active_ff <= 1'b0;
        end else begin
            // A mode switch can line up edges of two sources; the
            // second is dropped so the line tick stays a pulse.
            fc_ref_tick_ff <= nxt_tick && !fc_ref_tick_ff;
            ref_source_ff <= nxt_src;
            sensor_clk_oe_ff <= nxt_oe;
            legacy_video_active_ff <= (mode_ff == `SCMC_MODE_LEGACY);
        end
    end

    // =====================================================
    // Sensor clock generation
    // The loop runs on clk; its output is a slow square wave
    wire dpll_clk;

    scmc_dpll u_dpll (
        .clk(clk),
        .arst_n(arst_n),
        .fc_tick(fc_ref_tick_ff),
        .div_code(div_code_ff),
        .mult(mult_ff),
        .ndiv(ndiv_ff),
        .clk_ff(dpll_clk)
    );

    // Held low whenever the output is disabled
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sensor_clk_out_ff <= 1'b0;
        end else begin
            sensor_clk_out_ff <= dpll_clk && nxt_oe; // see [R5] [R1]
        end
    end
endmodule // scmc_clock_mode_ctrl

`default_nettype wire

// file: tb/scmc_sensor_model.sv
// Image sensor and link partner model: reference clocks and clock sink
`timescale 1ns/100ps
`default_nettype none

module scmc_sensor_model (
    input wire logic sensor_clk,
    input wire logic sensor_clk_oe,
    output logic ref_clk,
    output logic bc_clk,
    output logic [15:0] rises
);
    // =====================================================
    // Free-running sources, phase unrelated to the bench clock
    initial begin
        ref_clk = 1'b0;
        forever #122 ref_clk = ~ref_clk;
    end
    initial begin
        bc_clk = 1'b0;
        forever #83.3 bc_clk = ~bc_clk;
    end
    // =====================================================
    // Sensor side counts only edges it is allowed to use
    // No camera data is sent, so throughput stays under the line rate
    logic [15:0] cnt = 16'h0000;
    assign rises = cnt;
    always @(posedge sensor_clk) begin
        if (sensor_clk_oe === 1'b1) begin
            cnt <= cnt + 16'h0001;
        end
    end
endmodule // scmc_sensor_model

`default_nettype wire

// file: tb/scmc_chk_assertions.sv
// Concurrent checks on the clock mode control ports
`timescale 1ns/100ps
`default_nettype none

module scmc_chk (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pwrite,
    input wire logic pready_ff,
    input wire logic pslverr_ff,
    input wire logic sensor_clk_out_ff,
    input wire logic sensor_clk_oe_ff,
    input wire logic fc_ref_tick_ff,
    input wire logic [1:0] ref_source_ff,
    input wire logic legacy_video_active_ff,
    input wire logic fmt_override_ff,
    input wire logic [5:0] legacy_datatype_ff
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    // =====================================================
    // Register bus
    chk_apb_ready: assert property (
        psel && !penable |=> pready_ff)
        else $error("no ready after setup");
    chk_ready_pulse: assert property (
        pready_ff |=> !pready_ff)
        else $error("ready held too long");
    chk_err_ready: assert property (
        pslverr_ff |-> pready_ff)
        else $error("error without ready");
    chk_unmapped_err: assert property (
        psel && !penable && paddr[7:2] == 6'h20 |=> pslverr_ff)
        else $error("unmapped access not refused");
    chk_fmt_write: assert property (
        psel && penable && pready_ff && pwrite && paddr[7:2] == 6'h04
        |=> fmt_override_ff == $past(pwdata[0]))
        else $error("format override not written");
    chk_vdt_write: assert property (
        psel && penable && pready_ff && pwrite && paddr[7:2] == 6'h11
        |=> legacy_datatype_ff == $past(pwdata[5:0]))
        else $error("datatype not written");
    // =====================================================
    // Clock scheme
    chk_int_no_clk: assert property (
        ref_source_ff == 2'h3 |-> !sensor_clk_oe_ff)
        else $error("sensor clock enabled in internal mode");
    chk_clk_quiet: assert property (
        !sensor_clk_oe_ff [*3] |-> !sensor_clk_out_ff)
        else $error("sensor clock toggles while disabled");
    chk_legacy_ext: assert property (
        legacy_video_active_ff |-> ref_source_ff == 2'h2 && sensor_clk_oe_ff)
        else $error("legacy mode not on external clock");
    chk_sync_bc: assert property (
        ref_source_ff == 2'h1 |-> sensor_clk_oe_ff)
        else $error("sync mode without sensor clock");
    chk_tick_pulse: assert property (
        fc_ref_tick_ff |=> !fc_ref_tick_ff)
        else $error("line tick longer than one cycle");

    cov_legacy: cover property (legacy_video_active_ff);
    cov_internal: cover property (ref_source_ff == 2'h3 && fc_ref_tick_ff);
    cov_refused: cover property (pslverr_ff);
endmodule // scmc_chk

bind scmc_clock_mode_ctrl scmc_chk i_chk (
    .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .paddr(paddr), .pwdata(pwdata), .pwrite(pwrite),
    .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
    .sensor_clk_out_ff(sensor_clk_out_ff),
    .sensor_clk_oe_ff(sensor_clk_oe_ff), .fc_ref_tick_ff(fc_ref_tick_ff),
    .ref_source_ff(ref_source_ff),
    .legacy_video_active_ff(legacy_video_active_ff),
    .fmt_override_ff(fmt_override_ff),
    .legacy_datatype_ff(legacy_datatype_ff)
);

`default_nettype wire

// file: tb/testbench.sv
// Self-checking testbench for the clock mode control block
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, e, g) begin \
    n_checks++; \
    if ((e) !== (g)) begin \
        error_cnt++; \
        $display("[ERR] %s exp %h got %h", nm, e, g); \
    end \
end

module testbench;
    logic clk, arst_n, psel, penable, pwrite, powerdown_n;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [2:0] mode_strap;
    wire [31:0] prdata_ff;
    wire pready_ff, pslverr_ff, ref_clk, bc_clk, sclk, sclk_oe, tick;
    wire [1:0] ref_source_ff;
    wire legacy_video_active_ff, fmt_override_ff, fmt_raw12_ff;
    wire pass_long_ff, pass_yuv_ff, datatype_match_enable_ff;
    wire [5:0] legacy_datatype_ff;
    wire [15:0] rises;
    int error_cnt = 0;
    int n_checks = 0;
    int seed, i, ticks = 0, t0, r0, dt;
    logic [7:0] v;
    logic [9:0] expq[$];
    logic [9:0] mon_e;
    logic [2:0] modes [4] = '{3'h0, 3'h2, 3'h3, 3'h5};
    logic [1:0] srcs [4] = '{2'h1, 2'h2, 2'h3, 2'h2};
    logic oes [4] = '{1'b1, 1'b1, 1'b0, 1'b1};

    scmc_clock_mode_ctrl i_dut (
        .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata_ff(prdata_ff), .pready_ff(pready_ff),
        .pslverr_ff(pslverr_ff), .powerdown_n(powerdown_n),
        .mode_strap(mode_strap), .ref_clock_input(ref_clk),
        .bc_recovered_clk(bc_clk), .sensor_clk_out_ff(sclk),
        .sensor_clk_oe_ff(sclk_oe), .fc_ref_tick_ff(tick),
        .ref_source_ff(ref_source_ff),
        .legacy_video_active_ff(legacy_video_active_ff),
        .fmt_override_ff(fmt_override_ff), .fmt_raw12_ff(fmt_raw12_ff),
        .pass_long_ff(pass_long_ff), .pass_yuv_ff(pass_yuv_ff),
        .datatype_match_enable_ff(datatype_match_enable_ff),
        .legacy_datatype_ff(legacy_datatype_ff)
    );
    scmc_sensor_model i_sensor (
        .sensor_clk(sclk), .sensor_clk_oe(sclk_oe), .ref_clk(ref_clk),
        .bc_clk(bc_clk), .rises(rises)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // =====================================================
    // Bus master: note the expectation, then run one transfer
    task automatic apb(input logic [7:0] a, input logic w,
                       input logic [7:0] d, input logic [7:0] exp,
                       input logic err);
        logic [31:0] rnd;
        rnd = $random(seed);
        expq.push_back({w, err, exp});
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {rnd[23:0], d};
        @(posedge clk);
        penable <= 1'b1;
        // Wait states are the slave's business; the watchdog ends a hang
        do begin
            @(posedge clk);
        end while (pready_ff !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    always @(posedge clk) begin
        if (tick === 1'b1) begin
            ticks <= ticks + 1;
        end
        if (psel && penable && pready_ff === 1'b1) begin
            mon_e = expq.pop_front();
            if (!mon_e[9]) begin
                `CHK("prdata", 32'(mon_e[7:0]), prdata_ff)
            end
            `CHK("pslverr", mon_e[8], pslverr_ff)
        end
    end

    task automatic final_report;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge clk);
        error_cnt++;
        final_report();
    end

    // =====================================================
    // Main sequence
    initial begin
        seed = 19746;
        arst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        powerdown_n = 1'b0;
        mode_strap = 3'h5;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK("src_reset", 2'h1, ref_source_ff)
        powerdown_n <= 1'b1;
        repeat (8) @(posedge clk);
        `CHK("strap_legacy", 1'b1, legacy_video_active_ff)
        apb(8'h0C, 0, 8'h00, 8'h05, 0);
        apb(8'h0C, 1, 8'h02, 8'h00, 0);
        apb(8'h0C, 0, 8'h00, 8'h05, 0);
        apb(8'h0C, 1, 8'h10, 8'h00, 0);
        apb(8'h0C, 0, 8'h00, 8'h15, 0);
        for (i = 0; i < 4; i++) begin
            apb(8'h0C, 1, {5'h02, modes[i]}, 8'h00, 0);
            apb(8'h0C, 0, 8'h00, {5'h02, modes[i]}, 0);
            repeat (4) @(posedge clk);
            `CHK("src", srcs[i], ref_source_ff)
            `CHK("oe", oes[i], sclk_oe)
            `CHK("lgc", modes[i] == 3'h5, legacy_video_active_ff)
        end
        // Line tick rate in internal mode follows the oscillator select
        apb(8'h0C, 1, 8'h13, 8'h00, 0);
        for (i = 0; i < 2; i++) begin
            v = {4'h0, i[0], 3'h0};
            apb(8'h14, 1, v, 8'h00, 0);
            apb(8'h14, 0, 8'h00, v, 0);
            t0 = ticks;
            repeat (40) @(posedge clk);
            dt = ticks - t0;
            `CHK("aon", 1'b1, dt inside {[9 + 10*i:11 + 12*i]})
        end
        // External mode: divide 2, M 1, N 3 gives a period per 6 ticks
        apb(8'h0C, 1, 8'h12, 8'h00, 0);
        apb(8'h18, 0, 8'h00, 8'h41, 0);
        apb(8'h18, 1, 8'h21, 8'h00, 0);
        apb(8'h1C, 1, 8'h03, 8'h00, 0);
        apb(8'h48, 0, 8'h00, 8'hD6, 0);
        t0 = ticks;
        r0 = int'(rises);
        repeat (3000) @(posedge clk);
        dt = (ticks - t0) - 6 * (int'(rises) - r0);
        `CHK("ratio", 1'b1, dt inside {[-8:8]})
        for (i = 0; i < 3; i++) begin
            v = 8'($random(seed));
            apb(8'h10, 1, v, 8'h00, 0);
            apb(8'h40, 1, v, 8'h00, 0);
            apb(8'h44, 1, v, 8'h00, 0);
            apb(8'h10, 0, 8'h00, v & 8'h03, 0);
            apb(8'h40, 0, 8'h00, v & 8'h07, 0);
            apb(8'h44, 0, 8'h00, v & 8'h3F, 0);
            `CHK("fmt", v[1:0], {fmt_raw12_ff, fmt_override_ff})
            `CHK("long", v[0], pass_long_ff)
            `CHK("yuv", v[1], pass_yuv_ff)
            `CHK("dtm", v[2], datatype_match_enable_ff)
            `CHK("vdt", v[5:0], legacy_datatype_ff)
        end
        apb(8'h80, 1, 8'hFF, 8'h00, 1);
        apb(8'h80, 0, 8'h00, 8'h00, 1);
        repeat (2) @(posedge clk);
        final_report();
    end
endmodule // testbench

`default_nettype wire
